// ===== src/fbp_flash_ctrl.sv
// Flash block controller: word array, per-block erase sequencer, pair protection.
// Assumes requesters hold req until ack; one request at a time.
//
// Overview of operation
// - Manage 128 KB array for all ops
// - Erase one 1-KB block alone
// - Erased block reads all ones
// - Protection granule is a 2-KB pair
// - Region: unprotected, read-only or execute-only
// - Read-only refuses erase/program, allows reads
// - Execute-only refuses erase and program
// - Execute-only serves instruction fetches only
module fbp_flash_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Access request
  input wire logic req,
  input wire fbp_pkg::fbp_op_t req_op,
  input wire fbp_pkg::fbp_src_t req_src,
  input wire logic [fbp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [fbp_pkg::DATA_W-1:0] req_wdata,
  // Access answer
  output logic ack,
  output logic denied,
  output logic [fbp_pkg::DATA_W-1:0] rdata,
  // Protection setup
  input wire logic prot_set,
  input wire logic [fbp_pkg::REGION_W-1:0] prot_region,
  input wire fbp_pkg::fbp_prot_t prot_value,
  // Status
  input wire logic viol_clear,
  output logic viol_flag,
  output logic busy
);
  logic [fbp_pkg::DATA_W-1:0] mem [fbp_pkg::NUM_WORDS];

  fbp_pkg::fbp_state_t state_reg;
  fbp_pkg::fbp_state_t state_next;
  logic [fbp_pkg::BLOCK_W-1:0] blk_reg;
  logic [fbp_pkg::WOFF_W-1:0] woff_reg;
  logic ack_reg;
  logic denied_reg;
  logic viol_reg;
  logic [fbp_pkg::DATA_W-1:0] rdata_reg;

  function automatic logic [fbp_pkg::BLOCK_W-1:0] block_of(input logic [fbp_pkg::ADDR_W-1:0] a);
    block_of = a[fbp_pkg::ADDR_W-1:fbp_pkg::WOFF_W];
  endfunction : block_of

  // Pair of blocks shares one region index
  function automatic logic [fbp_pkg::REGION_W-1:0] region_of(input logic [fbp_pkg::BLOCK_W-1:0] b);
    region_of = b[fbp_pkg::BLOCK_W-1:1];
  endfunction : region_of

  function automatic logic is_op(input fbp_pkg::fbp_op_t have, input fbp_pkg::fbp_op_t want);
    is_op = (have == want);
  endfunction : is_op

  // Verdict is combinational, ready in the taking cycle
  fbp_chk_if chk ();
  fbp_prot_check u_check (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_en(prot_set),
    .set_region(prot_region),
    .set_prot(prot_value),
    .chk(chk)
  );

  wire [fbp_pkg::BLOCK_W-1:0] req_blk = block_of(req_addr);
  assign chk.region = region_of(req_blk);
  assign chk.op = req_op;
  assign chk.src = req_src;

  // State decode
  wire idle = (state_reg == fbp_pkg::FBP_ST_IDLE);
  wire erasing = (state_reg == fbp_pkg::FBP_ST_ERASE);
  wire finishing = (state_reg == fbp_pkg::FBP_ST_DONE);

  // Ack cycle blocks re-taking a still-held request
  wire take = idle && req && !ack_reg;
  wire permit = take && chk.allow;
  wire refuse = take && !chk.allow;

  wire op_read = is_op(req_op, fbp_pkg::FBP_REQ_READ);
  wire op_prog = is_op(req_op, fbp_pkg::FBP_REQ_PROGRAM);
  wire op_erase = is_op(req_op, fbp_pkg::FBP_REQ_ERASE);

  wire region_locked = (chk.prot != fbp_pkg::FBP_PROT_NONE);
  wire may_modify = permit && !region_locked;

  wire do_read = permit && op_read;
  wire do_prog = may_modify && op_prog;
  wire do_erase = may_modify && op_erase;

  // Sweep addressing
  wire last_word = (woff_reg == fbp_pkg::WOFF_W'(fbp_pkg::WORDS_PER_BLOCK - 1));
  wire [fbp_pkg::ADDR_W-1:0] erase_addr = {blk_reg, woff_reg};
  wire [fbp_pkg::WOFF_W-1:0] woff_next = woff_reg + 1'b1;

  // Array write port
  wire mem_we = erasing || do_prog;
  wire [fbp_pkg::ADDR_W-1:0] mem_waddr = erasing ? erase_addr : req_addr;
  // Sweep writes ones
  // Program only clears bits, as flash cells do
  wire [fbp_pkg::DATA_W-1:0] mem_wdata = erasing ? fbp_pkg::ERASED_WORD : (mem[req_addr] & req_wdata);

  // Answer decode
  wire ack_next = (take && !do_erase) || finishing;
  wire denied_next = refuse;
  wire [fbp_pkg::DATA_W-1:0] rdata_next = do_read ? mem[req_addr] : fbp_pkg::DENIED_WORD;

  wire viol_next = refuse || (viol_reg && !viol_clear);

  // Erase holds the machine; word accesses answer from idle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      fbp_pkg::FBP_ST_IDLE: begin
        if (do_erase) begin
          state_next = fbp_pkg::FBP_ST_ERASE;
        end
      end
      fbp_pkg::FBP_ST_ERASE: begin
        if (last_word) begin
          state_next = fbp_pkg::FBP_ST_DONE;
        end
      end
      fbp_pkg::FBP_ST_DONE: begin
        state_next = fbp_pkg::FBP_ST_IDLE;
      end
      default: begin
        state_next = fbp_pkg::FBP_ST_IDLE;
      end
    endcase
  end

  // Gray path: idle, sweep, done
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= fbp_pkg::FBP_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Block latched once per erase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      blk_reg <= '0;
    end else if (do_erase) begin
      blk_reg <= req_blk;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      woff_reg <= '0;
    end else if (do_erase) begin
      woff_reg <= '0;
    end else if (erasing) begin
      woff_reg <= woff_next;
    end
  end

  // Array writes: refused requests never reach here
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // Answer pulses last one cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      denied_reg <= 1'b0;
    end else begin
      denied_reg <= denied_next;
    end
  end

  // Read data holds until the next taken request
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_reg <= fbp_pkg::DENIED_WORD;
    end else if (take) begin
      rdata_reg <= rdata_next;
    end
  end

  // Cleared only by viol_clear or reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      viol_reg <= 1'b0;
    end else begin
      viol_reg <= viol_next;
    end
  end

  // Outputs straight from flops
  assign ack = ack_reg;
  assign denied = denied_reg;
  assign rdata = rdata_reg;
  assign viol_flag = viol_reg;
  // Busy is a state bit: high in sweep and done cycles
  assign busy = state_reg[0];
endmodule : fbp_flash_ctrl

// ===== inc/fbp_pkg.sv
// Package: geometry, protection codes and sequencer states for the flash block controller.
// Assumes a single clock domain and word-wide (32-bit) array access.
package fbp_pkg;
  localparam int unsigned ARRAY_BYTES = 131072;
  localparam int unsigned BLOCK_BYTES = 1024;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned NUM_WORDS = ARRAY_BYTES / WORD_BYTES;
  localparam int unsigned NUM_BLOCKS = ARRAY_BYTES / BLOCK_BYTES;
  localparam int unsigned NUM_REGIONS = NUM_BLOCKS / 2;
  localparam int unsigned WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned BLOCK_W = 7;
  localparam int unsigned REGION_W = 6;
  localparam int unsigned WOFF_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffff_ffff;
  localparam logic [DATA_W-1:0] DENIED_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    FBP_PROT_NONE = 2'h0,
    FBP_PROT_READ_ONLY = 2'h1,
    FBP_PROT_EXEC_ONLY = 2'h2
  } fbp_prot_t;

  typedef enum logic [1:0] {
    FBP_REQ_READ = 2'h0,
    FBP_REQ_PROGRAM = 2'h1,
    FBP_REQ_ERASE = 2'h2
  } fbp_op_t;

  typedef enum logic [1:0] {
    FBP_SRC_FETCH = 2'h0,
    FBP_SRC_DATA = 2'h1,
    FBP_SRC_DEBUG = 2'h2
  } fbp_src_t;

  typedef enum logic [1:0] {
    FBP_ST_IDLE = 2'b00,
    FBP_ST_ERASE = 2'b01,
    FBP_ST_DONE = 2'b11
  } fbp_state_t;
endpackage : fbp_pkg

// ===== inc/fbp_chk_if.sv
// Interface: carries an access request to the protection checker and its verdict back.
// Assumes the checker is purely combinational.
interface fbp_chk_if;
  logic [fbp_pkg::REGION_W-1:0] region;
  fbp_pkg::fbp_op_t op;
  fbp_pkg::fbp_src_t src;
  fbp_pkg::fbp_prot_t prot;
  logic allow;
  modport requester (output region, output op, output src, input prot, input allow);
  modport checker_side (input region, input op, input src, output prot, output allow);
endinterface : fbp_chk_if

// ===== src/fbp_prot_check.sv
// Protection checker: holds the per-region setting table and judges one access.
// Assumes table writes come from the owning controller in the same clock.
module fbp_prot_check (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Table update
  input wire logic set_en,
  input wire logic [fbp_pkg::REGION_W-1:0] set_region,
  input wire fbp_pkg::fbp_prot_t set_prot,
  // Query
  fbp_chk_if.checker_side chk
);
  fbp_pkg::fbp_prot_t prot_reg [fbp_pkg::NUM_REGIONS];
  wire fbp_pkg::fbp_prot_t cur_prot = prot_reg[chk.region];
  wire ro_deny = (cur_prot == fbp_pkg::FBP_PROT_READ_ONLY) && (chk.op != fbp_pkg::FBP_REQ_READ);
  wire xo_deny = (cur_prot == fbp_pkg::FBP_PROT_EXEC_ONLY) &&
                 ((chk.op != fbp_pkg::FBP_REQ_READ) || (chk.src != fbp_pkg::FBP_SRC_FETCH));

  assign chk.prot = cur_prot;
  assign chk.allow = !(ro_deny || xo_deny);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < fbp_pkg::NUM_REGIONS; i++) begin
        prot_reg[i] <= fbp_pkg::FBP_PROT_NONE;
      end
    end else if (set_en) begin
      prot_reg[set_region] <= set_prot;
    end
  end
endmodule : fbp_prot_check

// ===== testbench/fbp_ctrl_sva.sv
// Checker: answer timing and refusal of the flash block controller.
// Assumes it is bound to fbp_flash_ctrl.
module fbp_ctrl_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Access
  input wire logic req,
  input wire fbp_pkg::fbp_op_t req_op,
  input wire fbp_pkg::fbp_src_t req_src,
  input wire logic ack,
  input wire logic denied,
  input wire logic [fbp_pkg::DATA_W-1:0] rdata,
  // Status
  input wire logic viol_clear,
  input wire logic viol_flag,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire take = req && !busy && !ack;
  sequence s_erase_go;
    take && req_op == fbp_pkg::FBP_REQ_ERASE ##1 busy;
  endsequence
  denied_has_ack_a: assert property (denied |-> ack)
    else $error("denied without ack");
  flag_on_refusal_a: assert property (denied |-> viol_flag)
    else $error("refusal left flag low");
  flag_sticky_a: assert property (viol_flag && !viol_clear |=> viol_flag)
    else $error("flag dropped on its own");
  short_answer_a: assert property (take && req_op != fbp_pkg::FBP_REQ_ERASE |=> ack)
    else $error("word access not answered");
  erase_length_a: assert property (s_erase_go |-> ##257 (ack && !busy && !denied))
    else $error("erase sweep length wrong");
  fetch_served_a: assert property (take && req_src == fbp_pkg::FBP_SRC_FETCH && req_op == fbp_pkg::FBP_REQ_READ |=> !denied)
    else $error("fetch refused");
  denied_zero_a: assert property (denied |-> rdata == fbp_pkg::DENIED_WORD)
    else $error("refused read leaked data");
  ack_single_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
endmodule : fbp_ctrl_sva

bind fbp_flash_ctrl fbp_ctrl_sva i_sva (.clock(clock), .sys_rst(sys_rst), .req(req), .req_op(req_op),
  .req_src(req_src), .ack(ack), .denied(denied), .rdata(rdata), .viol_clear(viol_clear),
  .viol_flag(viol_flag), .busy(busy));

// ===== testbench/fbp_host_model.sv
// Partner: fetch, data and debug requester on the access bus.
// Assumes a one-cycle ack answers each request.
module fbp_host_model (
  // Clock
  input wire logic clock,
  // Request
  output logic req,
  output fbp_pkg::fbp_op_t req_op,
  output fbp_pkg::fbp_src_t req_src,
  output logic [14:0] req_addr,
  output logic [31:0] req_wdata,
  // Answer
  input wire logic ack,
  input wire logic denied,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    req = 1'b0;
    req_op = fbp_pkg::FBP_REQ_READ;
    req_src = fbp_pkg::FBP_SRC_FETCH;
    req_addr = 15'h0000;
    req_wdata = 32'h0000_0000;
  end
  // Idle address and write-data lines flip so a stale value never looks valid; op and source hold
  task automatic access(input fbp_pkg::fbp_op_t op, input fbp_pkg::fbp_src_t src, input logic [14:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic dn, output bit ok);
    int n;
    ok = 1'b0;
    @(negedge clock);
    req = 1'b1;
    req_op = op;
    req_src = src;
    req_addr = a;
    req_wdata = wd;
    for (n = 0; n < 300 && !ok; n++) begin
      @(negedge clock);
      ok = ack;
    end
    rd = rdata;
    dn = denied;
    req = 1'b0;
    req_addr = ~a;
    req_wdata = ~wd;
  endtask : access
endmodule : fbp_host_model

// ===== testbench/test_fbp_flash_ctrl.sv
// Testbench: erase, program and pair protection of the flash block controller.
// Assumes the host model drives the access bus.
module test_fbp_flash_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  localparam fbp_pkg::fbp_op_t RD = fbp_pkg::FBP_REQ_READ;
  localparam fbp_pkg::fbp_op_t PG = fbp_pkg::FBP_REQ_PROGRAM;
  localparam fbp_pkg::fbp_op_t ER = fbp_pkg::FBP_REQ_ERASE;
  localparam fbp_pkg::fbp_src_t FE = fbp_pkg::FBP_SRC_FETCH;
  localparam fbp_pkg::fbp_src_t DA = fbp_pkg::FBP_SRC_DATA;
  localparam fbp_pkg::fbp_src_t DB = fbp_pkg::FBP_SRC_DEBUG;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic req, ack, denied, viol_flag, busy, prot_set = 1'b0, viol_clear = 1'b0;
  fbp_pkg::fbp_op_t req_op;
  fbp_pkg::fbp_src_t req_src;
  fbp_pkg::fbp_prot_t prot_value = fbp_pkg::FBP_PROT_NONE;
  logic [14:0] req_addr;
  logic [31:0] req_wdata, rdata;
  logic [5:0] prot_region = 6'h00;
  int bad_count = 0;
  int checks = 0;
  fbp_flash_ctrl i_dut (.clock(clock), .sys_rst(sys_rst), .req(req), .req_op(req_op), .req_src(req_src),
    .req_addr(req_addr), .req_wdata(req_wdata), .ack(ack), .denied(denied), .rdata(rdata), .prot_set(prot_set),
    .prot_region(prot_region), .prot_value(prot_value), .viol_clear(viol_clear), .viol_flag(viol_flag), .busy(busy));
  fbp_host_model i_host (.clock(clock), .req(req), .req_op(req_op), .req_src(req_src), .req_addr(req_addr),
    .req_wdata(req_wdata), .ack(ack), .denied(denied), .rdata(rdata));
  initial begin
    forever #2 clock = ~clock;
  end
  task automatic test_done();
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("FAIL %0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask : cmp
  task automatic acc(input fbp_pkg::fbp_op_t op, input fbp_pkg::fbp_src_t src, input logic [14:0] a,
    input logic [31:0] wd, input logic [31:0] exp, input logic dn);
    logic [31:0] rd;
    logic d;
    bit ok;
    i_host.access(op, src, a, wd, rd, d, ok);
    if (!ok) begin
      bad_count++;
      test_done();
    end
    cmp(rd, exp);
    cmp({31'h0, d}, {31'h0, dn});
  endtask : acc
  task automatic prot(input logic [5:0] r, input fbp_pkg::fbp_prot_t v);
    @(negedge clock);
    prot_set = 1'b1;
    prot_region = r;
    prot_value = v;
    @(negedge clock);
    prot_set = 1'b0;
  endtask : prot
  task automatic t_erase();
    acc(ER, DA, 15'h0200, 32'h0, 32'h0, 1'b0);
    acc(PG, DA, 15'h0205, 32'h1234_5678, 32'h0, 1'b0);
    acc(ER, DA, 15'h0300, 32'h0, 32'h0, 1'b0);
    acc(RD, DA, 15'h0205, 32'h0, 32'h1234_5678, 1'b0);
    acc(RD, DA, 15'h03ff, 32'h0, fbp_pkg::ERASED_WORD, 1'b0);
    acc(ER, DA, 15'h7f00, 32'h0, 32'h0, 1'b0);
    acc(RD, DB, 15'h7fff, 32'h0, fbp_pkg::ERASED_WORD, 1'b0);
  endtask : t_erase
  task automatic t_read_only();
    prot(6'h01, fbp_pkg::FBP_PROT_READ_ONLY);
    acc(PG, DA, 15'h0300, 32'h0, 32'h0, 1'b1);
    acc(ER, DA, 15'h0200, 32'h0, 32'h0, 1'b1);
    acc(RD, DB, 15'h0300, 32'h0, fbp_pkg::ERASED_WORD, 1'b0);
    acc(RD, DA, 15'h0205, 32'h0, 32'h1234_5678, 1'b0);
    cmp({31'h0, viol_flag}, 32'h1);
    viol_clear = 1'b1;
    @(negedge clock);
    viol_clear = 1'b0;
    cmp({31'h0, viol_flag}, 32'h0);
  endtask : t_read_only
  task automatic t_exec_only();
    prot(6'h01, fbp_pkg::FBP_PROT_EXEC_ONLY);
    viol_clear = 1'b1;
    acc(RD, DA, 15'h0205, 32'h0, fbp_pkg::DENIED_WORD, 1'b1);
    cmp({31'h0, viol_flag}, 32'h1);
    viol_clear = 1'b0;
    acc(RD, DB, 15'h0205, 32'h0, fbp_pkg::DENIED_WORD, 1'b1);
    acc(RD, FE, 15'h0205, 32'h0, 32'h1234_5678, 1'b0);
    acc(ER, FE, 15'h0300, 32'h0, 32'h0, 1'b1);
    prot(6'h01, fbp_pkg::FBP_PROT_NONE);
    acc(PG, DA, 15'h0300, 32'h00ff_00ff, 32'h0, 1'b0);
    acc(RD, DA, 15'h0300, 32'h0, 32'h00ff_00ff, 1'b0);
  endtask : t_exec_only
  initial begin
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    t_erase();
    t_read_only();
    t_exec_only();
    test_done();
  end
endmodule : test_fbp_flash_ctrl
